// file: design/pcd_datapath.sv
// phase channel datapath: dc block, integrator, voltage gain, routing, waveform capture
// assumes synchronous adc strobes and a single-cycle register port from the serial block
`timescale 1ns/100ps
`include "pcd_map.svh"

// ----------------------------------------
// sample fifo toward the power engine
// ----------------------------------------
module pcd_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic full;
        logic empty;
    } pcd_fifo_st_t;
    pcd_fifo_st_t f_reg;
    pcd_fifo_st_t f_next;
    logic push;
    logic pop;

    // pointers wrap freely, so depth must be a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("pcd_fifo depth must be a power of two of at least 2");
    end

    // flags are recomputed from the next count so both stay registered
    always_comb begin
        f_next = f_reg;
        push = in_valid && !f_reg.full;
        pop = out_ready && !f_reg.empty;
        if (push) begin
            f_next.mem[f_reg.wp] = in_data;
            f_next.wp = f_reg.wp + 1'b1;
        end
        if (pop) begin
            f_next.rp = f_reg.rp + 1'b1;
        end
        f_next.cnt = f_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        f_next.full = (f_next.cnt == (AW+1)'(DEPTH));
        f_next.empty = (f_next.cnt == '0);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            f_reg <= '0;
            f_reg.empty <= 1'b1;
        end else begin
            f_reg <= f_next;
        end
    end

    assign in_ready = !f_reg.full;
    assign out_valid = !f_reg.empty;
    assign out_data = f_reg.mem[f_reg.rp];
endmodule

// ----------------------------------------
// datapath top
// ----------------------------------------
module pcd_datapath
    import pcd_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire pcd_req_t reg_req,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // adc sample input
    input wire logic adc_valid,
    input wire pcd_smp_t adc_data,
    output logic adc_ready,
    // stream toward the power engine
    output logic path_valid,
    output pcd_smp_t path_data,
    input wire logic path_ready,
    // interrupt, active high
    output logic irq
);
    pcd_state_t s_reg;
    pcd_state_t s_next;
    pcd_smp_t pdata;
    logic push;
    logic fifo_ready;

    // clamp a wide signed result into the 24-bit sample range
    function automatic logic [23:0] sat24(input logic signed [55:0] v);
        logic [23:0] r;
        r = v[23:0];
        if (v > 56'sh7FFFFF) begin
            r = 24'h7FFFFF;
        end else if (v < -56'sh800000) begin
            r = 24'h800000;
        end
        return r;
    endfunction

    // 24-bit signed word as a 32-bit word with 4 zero bits over a 28-bit extension
    function automatic logic [31:0] ext28(input logic [23:0] v);
        return {4'h0, {4{v[23]}}, v};
    endfunction

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        logic [6:0][23:0] raw;
        logic [6:0][23:0] flt;
        logic [2:0][23:0] cur;
        logic [2:0][23:0] vol;
        logic signed [31:0] hy;
        logic signed [55:0] acc;
        logic signed [55:0] prod;
        logic [1:0] code;
        int dst;
        raw = adc_data;
        flt = raw;
        cur = '0;
        vol = '0;
        hy = '0;
        acc = '0;
        prod = '0;
        code = '0;
        dst = 0;
        s_next = s_reg;
        pdata = '0;
        push = 1'b0;
        s_next.rvalid = 1'b0;
        // write side; clearing the ready flag comes first so a new sample wins
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                `PCD_ADDR_HPF_DIS: s_next.regs.hpf_dis = reg_req.wdata[23:0];
                `PCD_ADDR_CFG: s_next.regs.cfg = reg_req.wdata[15:0];
                `PCD_ADDR_INT_COEF: s_next.regs.coef = reg_req.wdata[23:0];
                `PCD_ADDR_IRQ_MASK_WORD_ZERO: s_next.regs.irq_mask_word_zero = reg_req.wdata;
                `PCD_ADDR_STATUS_WORD_ZERO: begin
                    if (reg_req.wdata[`PCD_BIT_READY]) begin
                        s_next.regs.ready_flag = 1'b0;
                    end
                end
                default: begin
                    for (int p = 0; p < 3; p++) begin
                        if (reg_req.addr == `PCD_ADDR_VGAIN_A + 8'(p)) begin
                            s_next.regs.vgain[p] = reg_req.wdata[23:0];
                        end
                    end
                end
            endcase
        end
        // read side; unmapped words read zero
        if (reg_req.rd) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = 32'h00000000;
            unique case (reg_req.addr)
                `PCD_ADDR_HPF_DIS: s_next.rdata = {8'h00, s_reg.regs.hpf_dis};
                `PCD_ADDR_CFG: s_next.rdata = {16'h0000, s_reg.regs.cfg};
                `PCD_ADDR_INT_COEF: s_next.rdata = ext28(s_reg.regs.coef);
                `PCD_ADDR_IRQ_MASK_WORD_ZERO: s_next.rdata = s_reg.regs.irq_mask_word_zero;
                `PCD_ADDR_STATUS_WORD_ZERO: s_next.rdata[`PCD_BIT_READY] = s_reg.regs.ready_flag;
                default: begin
                    for (int p = 0; p < 3; p++) begin
                        if (reg_req.addr == `PCD_ADDR_VGAIN_A + 8'(p)) begin
                            s_next.rdata = ext28(s_reg.regs.vgain[p]);
                        end
                        if (reg_req.addr == `PCD_ADDR_IWAVE_A + 8'(p)) begin
                            s_next.rdata = {{8{s_reg.wave.cur[p][23]}}, s_reg.wave.cur[p]};
                        end
                        if (reg_req.addr == `PCD_ADDR_VWAVE_A + 8'(p)) begin
                            s_next.rdata = {{8{s_reg.wave.vol[p][23]}}, s_reg.wave.vol[p]};
                        end
                    end
                end
            endcase
        end
        // one sample set per accepted strobe; whole set is computed in this cycle,
        // so configuration is sampled once per set and never mid-set
        if (adc_valid && fifo_ready) begin
            // dc block: subtract a slow running mean, frozen while bypassed
            for (int i = 0; i < 7; i++) begin
                hy = 32'($signed(raw[i])) - ($signed(s_reg.dc[i]) >>> `PCD_HPF_SHIFT);
                if (s_reg.regs.hpf_dis == 24'h000000) begin
                    flt[i] = sat24(56'(hy));
                    s_next.dc[i] = s_reg.dc[i] + hy;
                end else begin
                    flt[i] = raw[i];
                end
            end
            // integrator on currents; coefficient sets the leak and is ignored when off
            for (int p = 0; p < 3; p++) begin
                if (s_reg.regs.cfg[`PCD_BIT_INT_ON]) begin
                    prod = 56'($signed(s_reg.integ[p])) * 56'($signed(s_reg.regs.coef));
                    acc = 56'($signed(s_reg.integ[p])) + 56'($signed(flt[4+p]))
                        + (prod >>> `PCD_GAIN_SHIFT);
                    s_next.integ[p] = acc[31:0];
                    cur[p] = sat24(acc >>> `PCD_INT_SHIFT);
                end else begin
                    s_next.integ[p] = 32'h00000000;
                    cur[p] = flt[4+p];
                end
            end
            // voltage gain: v + v*g/2^23
            for (int p = 0; p < 3; p++) begin
                prod = 56'($signed(flt[p])) * 56'($signed(s_reg.regs.vgain[p]));
                vol[p] = sat24(56'($signed(flt[p])) + (prod >>> `PCD_GAIN_SHIFT));
            end
            s_next.wave.cur = cur;
            s_next.wave.neu = flt[3];
            s_next.wave.vol = vol;
            s_next.regs.ready_flag = 1'b1;
            // routing: a path no source selects carries zero; lower source wins a tie
            pdata.cur = cur;
            pdata.neu = flt[3];
            for (int s = 2; s >= 0; s--) begin
                code = s_reg.regs.cfg[`PCD_LSB_ROUTE_A + 2*s +: 2];
                dst = s;
                if (code == 2'b01) begin
                    dst = (s + 1) % 3;
                end else if (code == 2'b10) begin
                    dst = (s + 2) % 3;
                end
                pdata.vol[dst] = vol[s];
            end
            push = 1'b1;
        end
        s_next.irq = s_next.regs.ready_flag && s_next.regs.irq_mask_word_zero[`PCD_BIT_READY];
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.regs.hpf_dis <= `PCD_RST_HPF_DIS;
            s_reg.regs.cfg <= `PCD_RST_CFG;
            s_reg.regs.coef <= `PCD_RST_COEF;
            s_reg.regs.vgain <= {3{`PCD_RST_VGAIN}};
            s_reg.regs.irq_mask_word_zero <= `PCD_RST_IRQ_MASK_WORD_ZERO;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------
    // stream buffer; its full flag stalls the adc source
    // ----------------------------------------
    pcd_fifo #(
        .W($bits(pcd_smp_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(push),
        .in_data(pdata),
        .in_ready(fifo_ready),
        .out_valid(path_valid),
        .out_data(path_data),
        .out_ready(path_ready)
    );

    assign adc_ready = fifo_ready;
    assign reg_rdata = s_reg.rdata;
    assign reg_rvalid = s_reg.rvalid;
    assign irq = s_reg.irq;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_bypass;
        @(posedge clock) disable iff (!rst_n)
        adc_valid && adc_ready && s_reg.regs.hpf_dis != 24'h000000
            && !s_reg.regs.cfg[0] |=> s_reg.wave.cur[0] == $past(adc_data.cur[0]);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypassed current differs");

    property p_ready_set;
        @(posedge clock) disable iff (!rst_n)
        adc_valid && adc_ready |=> s_reg.regs.ready_flag;
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready flag not set");

    property p_irq;
        @(posedge clock) disable iff (!rst_n)
        irq == (s_reg.regs.ready_flag && s_reg.regs.irq_mask_word_zero[17]);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt disagrees with flag");

    property p_wave_read;
        @(posedge clock) disable iff (!rst_n)
        reg_req.rd && reg_req.addr == 8'h06 |=> reg_rvalid
            && reg_rdata == {{8{$past(s_reg.wave.cur[0][23])}}, $past(s_reg.wave.cur[0])};
    endproperty
    a_wave_read: assert property (p_wave_read) else $error("wave read not sign-extended");

    property p_hpf_read;
        @(posedge clock) disable iff (!rst_n)
        reg_req.rd && reg_req.addr == 8'h00 |=> reg_rdata[31:24] == 8'h00;
    endproperty
    a_hpf_read: assert property (p_hpf_read) else $error("disable word upper bits set");

    property p_coef_read;
        @(posedge clock) disable iff (!rst_n)
        reg_req.rd && reg_req.addr == 8'h02 |=> reg_rdata[31:28] == 4'h0
            && reg_rdata[27:24] == {4{reg_rdata[23]}};
    endproperty
    a_coef_read: assert property (p_coef_read) else $error("coefficient read malformed");

    property p_route_a;
        @(posedge clock) disable iff (!rst_n)
        push && s_reg.regs.cfg[9:8] == 2'b01 |=> $past(pdata.vol[1]) == s_reg.wave.vol[0];
    endproperty
    a_route_a: assert property (p_route_a) else $error("phase a voltage not on path b");

    property p_integ_off;
        @(posedge clock) disable iff (!rst_n)
        push && !s_reg.regs.cfg[0] |=> s_reg.integ[0] == 32'h0 && s_reg.integ[2] == 32'h0;
    endproperty
    a_integ_off: assert property (p_integ_off) else $error("integrator ran while off");

    property p_unity_gain;
        @(posedge clock) disable iff (!rst_n)
        push && s_reg.regs.hpf_dis != 24'h0 && s_reg.regs.vgain[2] == 24'h0
            |=> s_reg.wave.vol[2] == $past(adc_data.vol[2]);
    endproperty
    a_unity_gain: assert property (p_unity_gain) else $error("zero gain altered voltage");
endmodule

// file: design/pcd_map.svh
// offsets, field positions, reset values and shifts of the phase channel datapath
// assumes word-indexed register access on the device's own serial register port
`ifndef PCD_MAP_SVH
`define PCD_MAP_SVH
`define PCD_ADDR_HPF_DIS 8'h00
`define PCD_ADDR_CFG 8'h01
`define PCD_ADDR_INT_COEF 8'h02
`define PCD_ADDR_VGAIN_A 8'h03
`define PCD_ADDR_IWAVE_A 8'h06
`define PCD_ADDR_VWAVE_A 8'h09
`define PCD_ADDR_STATUS_WORD_ZERO 8'h0C
`define PCD_ADDR_IRQ_MASK_WORD_ZERO 8'h0D
`define PCD_BIT_READY 17
`define PCD_BIT_INT_ON 0
`define PCD_LSB_ROUTE_A 8
`define PCD_RST_HPF_DIS 24'h000000
`define PCD_RST_CFG 16'h0000
`define PCD_RST_COEF 24'h000000
`define PCD_RST_VGAIN 24'h000000
`define PCD_RST_IRQ_MASK_WORD_ZERO 32'h00000000
`define PCD_HPF_SHIFT 8
`define PCD_INT_SHIFT 8
`define PCD_GAIN_SHIFT 23
`endif

// file: design/pcd_pkg.sv
// types shared by the phase channel datapath
// assumes nothing beyond the constants header
package pcd_pkg;
    typedef logic [23:0] pcd_w24_t;
    // one sample set: phase currents, neutral, phase voltages
    typedef struct packed {
        pcd_w24_t [2:0] cur;
        pcd_w24_t neu;
        pcd_w24_t [2:0] vol;
    } pcd_smp_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } pcd_req_t;
    typedef struct packed {
        pcd_w24_t hpf_dis;
        logic [15:0] cfg;
        pcd_w24_t coef;
        pcd_w24_t [2:0] vgain;
        logic [31:0] irq_mask_word_zero;
        logic ready_flag;
    } pcd_regs_t;
    typedef struct packed {
        pcd_regs_t regs;
        logic [6:0][31:0] dc;
        logic [2:0][31:0] integ;
        pcd_smp_t wave;
        logic [31:0] rdata;
        logic rvalid;
        logic irq;
    } pcd_state_t;
endpackage

// file: tb/pcd_engine_model.sv
// power engine stand-in that drains the datapath stream
// assumes one clock and the stream handshake of the datapath top
`timescale 1ns/100ps

// ----------------------------------------
// sink pacing
// ----------------------------------------
module pcd_engine_model
    import pcd_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // pacing from the bench
    input wire logic stall,
    input wire logic slow,
    // stream side
    output logic path_ready
);
    logic [7:0] lfsr_reg;
    // pattern changes every cycle so stalls fall in mid-burst
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lfsr_reg <= 8'hA5;
        end else begin
            lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
        end
    end
    // ready is a plain level: the engine never asks for a held head twice
    assign path_ready = rst_n && !stall && (!slow || lfsr_reg[0]);
endmodule

// file: tb/tb_phase_channel_datapath.sv
// self-checking bench for the phase channel datapath
// assumes the design package, the constants header and the engine stand-in
`timescale 1ns/100ps
`include "pcd_map.svh"

// ----------------------------------------
// bench top
// ----------------------------------------
module tb_phase_channel_datapath
    import pcd_pkg::*;
;
    logic clock, rst_n, adc_valid, adc_ready, path_valid, path_ready, reg_rvalid, irq;
    logic stall, slow, chk_path, rd_n;
    pcd_req_t reg_req;
    pcd_smp_t adc_data, path_data;
    logic [31:0] reg_rdata, rd_e;
    logic [31:0] exp_rd[$];
    logic neg_q[$];
    pcd_smp_t exp_path[$];
    pcd_w24_t gains[3];
    logic [15:0] cfg_now;
    int n_fail, cmp_count, cycles;
    integer seed;

    pcd_datapath #(.FIFO_DEPTH(8)) dut_u (.clock(clock), .rst_n(rst_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .adc_valid(adc_valid),
        .adc_data(adc_data), .adc_ready(adc_ready), .path_valid(path_valid),
        .path_data(path_data), .path_ready(path_ready), .irq(irq));
    pcd_engine_model eng_u (.clock(clock), .rst_n(rst_n), .stall(stall), .slow(slow),
        .path_ready(path_ready));

    // gain values are picked so the product is exact and rounding cannot matter
    function automatic pcd_w24_t gain_v(pcd_w24_t v, pcd_w24_t g);
        logic signed [48:0] p;
        p = $signed(v) * $signed(g);
        return 24'($signed(v) + (p >>> 23));
    endfunction

    // expected stream word: own currents, gained voltages moved to their paths
    function automatic pcd_smp_t route(pcd_smp_t s);
        pcd_smp_t r;
        logic [1:0] sel;
        int d;
        r = s;
        r.vol = '0;
        for (int k = 2; k >= 0; k--) begin
            sel = cfg_now[8 + 2 * k +: 2];
            d = (sel == 2'h1) ? (k + 1) % 3 : (sel == 2'h2) ? (k + 2) % 3 : k;
            r.vol[d] = gain_v(s.vol[k], gains[k]);
        end
        return r;
    endfunction

    // voltages kept below a quarter of full scale so +50% never saturates
    function automatic pcd_smp_t rnd_set();
        pcd_smp_t s;
        logic [31:0] r;
        for (int k = 0; k < 3; k++) begin
            s.cur[k] = 24'($random(seed));
            r = $random(seed);
            s.vol[k] = {{3{r[21]}}, r[20:1], 1'b0};
        end
        s.neu = 24'($random(seed));
        return s;
    endfunction

    task automatic cmp32(string what, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic cmp_set(pcd_smp_t e, pcd_smp_t g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH path_data expected %h seen %h", e, g);
        end
    endtask

    task automatic report_and_stop();
        $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one access, then an idle cycle so strobes never re-assert in one time step
    task automatic reg_acc(logic w, logic [7:0] a, logic [31:0] d);
        reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clock);
        #1;
        reg_req = '0;
        @(posedge clock);
        #1;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        reg_acc(1'b1, a, d);
    endtask

    // n set: the read must differ from e (filtered or integrated value)
    task automatic rd(logic [7:0] a, logic [31:0] e, logic n = 1'b0);
        exp_rd.push_back(e);
        neg_q.push_back(n);
        reg_acc(1'b0, a, 32'h00000000);
    endtask

    task automatic send_set(pcd_smp_t s, output logic took);
        adc_data = s;
        adc_valid = 1'b1;
        @(posedge clock);
        took = adc_ready;
        // note the set at its taking edge: the engine may pop it one edge later
        if (took && chk_path) exp_path.push_back(route(s));
        #1;
        adc_valid = 1'b0;
        @(posedge clock);
        #1;
    endtask

    task automatic drain();
        for (int i = 0; i < 400 && path_valid !== 1'b0; i++) @(posedge clock);
        #1;
        cmp32("sets left unseen", 32'h0, 32'(exp_path.size()));
    endtask

    // ----------------------------------------
    // result watcher and hang guard
    // ----------------------------------------
    always @(posedge clock) begin
        if (reg_rvalid === 1'b1) begin
            rd_e = exp_rd.pop_front();
            rd_n = neg_q.pop_front();
            if (rd_n) cmp32("processed sample", 32'h1, {31'h0, reg_rdata !== rd_e});
            else cmp32("read data", rd_e, reg_rdata);
        end
        if (path_valid === 1'b1 && path_ready === 1'b1 && chk_path === 1'b1) begin
            cmp_set(exp_path.pop_front(), path_data);
        end
    end

    // whole run needs a few hundred cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        pcd_smp_t s;
        logic took;
        int n_took;
        pcd_w24_t gv;
        logic [15:0] cfgs[12];
        logic [7:0] ra[9];
        seed = 32'hFFBDC273;
        cfgs = '{16'h0000, 16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'h0800, 16'h0C00,
            16'h1000, 16'h2000, 16'h3000, 16'h1500, 16'h2A00};
        ra = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h0C, 8'h0D, 8'h20};
        gains = '{24'h400000, 24'hC00000, 24'h000000};
        rst_n = 1'b0;
        reg_req = '0;
        adc_valid = 1'b0;
        adc_data = '0;
        {stall, slow, chk_path, cfg_now} = '0;
        repeat (12) @(posedge clock);
        #1;
        rst_n = 1'b1;
        cmp32("ready after reset", 32'h1, {31'h0, adc_ready});
        foreach (ra[i]) rd(ra[i], 32'h00000000);
        $display("test reset values done");
        wr(`PCD_ADDR_HPF_DIS, 32'hFFFFFFFF);
        rd(`PCD_ADDR_HPF_DIS, 32'h00FFFFFF);
        wr(`PCD_ADDR_INT_COEF, 32'h00FF8000);
        rd(`PCD_ADDR_INT_COEF, 32'h0FFF8000);
        for (int k = 0; k < 3; k++) wr(8'(`PCD_ADDR_VGAIN_A + k), {8'h00, gains[k]});
        rd(`PCD_ADDR_VGAIN_A, 32'h00400000);
        rd(8'(`PCD_ADDR_VGAIN_A + 1), 32'h0FC00000);
        wr(8'h20, 32'hFFFFFFFF);
        rd(8'h20, 32'h00000000);
        $display("test register formats done");
        // coefficient is loaded but integrator off: currents pass untouched
        chk_path = 1'b1;
        foreach (cfgs[i]) begin
            cfg_now = cfgs[i];
            if (i == 4) wr(`PCD_ADDR_IRQ_MASK_WORD_ZERO, 32'h00020000);
            wr(`PCD_ADDR_CFG, {16'h0000, cfg_now});
            s = rnd_set();
            if (i == 0) s.cur[0] = 24'h900000;
            send_set(s, took);
            cmp32("set taken", 32'h1, {31'h0, took});
            for (int k = 0; k < 3; k++) begin
                rd(8'(`PCD_ADDR_IWAVE_A + k), {{8{s.cur[k][23]}}, s.cur[k]});
                gv = gain_v(s.vol[k], gains[k]);
                rd(8'(`PCD_ADDR_VWAVE_A + k), {{8{gv[23]}}, gv});
            end
            rd(`PCD_ADDR_STATUS_WORD_ZERO, 32'h00020000);
            cmp32("irq", {31'h0, i >= 4}, {31'h0, irq});
            wr(`PCD_ADDR_STATUS_WORD_ZERO, 32'h00020000);
            rd(`PCD_ADDR_STATUS_WORD_ZERO, 32'h00000000);
            cmp32("irq after clear", 32'h0, {31'h0, irq});
        end
        rd(`PCD_ADDR_CFG, {16'h0000, cfg_now});
        $display("test routing and capture done");
        stall = 1'b1;
        n_took = 0;
        for (int j = 0; j < 10; j++) begin
            send_set(rnd_set(), took);
            n_took += took;
        end
        cmp32("sets held while stalled", 32'h8, 32'(n_took));
        cmp32("ready while full", 32'h0, {31'h0, adc_ready});
        stall = 1'b0;
        slow = 1'b1;
        for (int j = 0; j < 20; j++) send_set(rnd_set(), took);
        drain();
        cmp32("ready after drain", 32'h1, {31'h0, adc_ready});
        $display("test buffering done");
        chk_path = 1'b0;
        slow = 1'b0;
        wr(`PCD_ADDR_HPF_DIS, 32'h00000000);
        s = '0;
        s.cur[0] = 24'h100000;
        s.vol[0] = 24'h100000;
        repeat (40) send_set(s, took);
        rd(`PCD_ADDR_IWAVE_A, 32'h00100000, 1'b1);
        rd(`PCD_ADDR_VWAVE_A, 32'h00180000, 1'b1);
        wr(`PCD_ADDR_HPF_DIS, 32'h00000001);
        send_set(s, took);
        rd(`PCD_ADDR_IWAVE_A, 32'h00100000);
        rd(`PCD_ADDR_VWAVE_A, 32'h00180000);
        $display("test dc block done");
        wr(`PCD_ADDR_CFG, 32'h00000001);
        send_set(s, took);
        rd(`PCD_ADDR_IWAVE_A, 32'h00100000, 1'b1);
        wr(`PCD_ADDR_CFG, 32'h00000000);
        send_set(s, took);
        rd(`PCD_ADDR_IWAVE_A, 32'h00100000);
        $display("test integrator done");
        repeat (4) @(posedge clock);
        cmp32("reads left unseen", 32'h0, 32'(exp_rd.size()));
        report_and_stop();
    end
endmodule
